// *** spc_pkg.sv ***
// Shared constants and types of the serial unit
// Assumes one system clock and an asynchronous active-high reset
`default_nettype none

package spc_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] DIVISOR_ADDR = 8'hA2;
   localparam logic [7:0] DIVISOR_RESET = 8'h00;

   // ------------------------------------------------------------
   // Word and buffer sizes
   // ------------------------------------------------------------
   localparam int WORD_W = 8;
   localparam int FIFO_DEPTH = 32;
   localparam logic [2:0] LAST_BIT = 3'h7;

   // ------------------------------------------------------------
   // Select-mode field encodings
   // ------------------------------------------------------------
   localparam logic [1:0] MODE_THREE_WIRE = 2'h0;
   localparam logic [1:0] MODE_SELECT_IN = 2'h1;
   localparam int MODE_OUT_BIT = 1;
   localparam int MODE_LEVEL_BIT = 0;

   // ------------------------------------------------------------
   // Master engine states
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b01,
      ST_XFER = 2'b10
   } spc_state_type;

endpackage : spc_pkg

`default_nettype wire

// *** spc_fifo.sv ***
// Word FIFO with a registered output stage
// Assumes the consumer pops only while out_valid is high
`default_nettype none

module spc_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] count;
      logic [WIDTH-1:0] data;
      logic valid;
   } spc_fifo_state_type;

   spc_fifo_state_type s;
   spc_fifo_state_type next_s;
   logic push;
   logic load;

   assign in_ready = s.count < (AW+1)'(DEPTH);
   assign out_data = s.data;
   assign out_valid = s.valid;

   // ------------------------------------------------------------
   // Storage and output stage
   // ------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      push = in_valid && in_ready;
      load = (!s.valid || out_ready) && (s.count != '0);
      if (push)
      begin
         next_s.mem[s.wp] = in_data;
         next_s.wp = s.wp + 1'b1;
      end
      if (load)
      begin
         next_s.data = s.mem[s.rp];
         next_s.valid = 1'b1;
         next_s.rp = s.rp + 1'b1;
      end
      else if (out_ready)
      begin
         next_s.valid = 1'b0;
      end
      next_s.count = s.count + (AW+1)'(push) - (AW+1)'(load);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         s <= '0;
      else
         s <= next_s;
   end

endmodule : spc_fifo

`default_nettype wire

// *** spc_unit.sv ***
// Serial unit: pin directions, select modes, master clock divider
// Assumes pins resolved outside; control levels come from the CPU side
`default_nettype none

module spc_unit
   import spc_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   output logic [7:0] SFR_RDATA,
   input wire logic ENABLE,
   input wire logic MASTER,
   input wire logic [1:0] SELECT_MODE,
   input wire logic CLEAR_LOST,
   output logic MASTER_LOST,
   output logic SELECT_ROUTED,
   input wire logic [spc_pkg::WORD_W-1:0] TX_DATA,
   input wire logic TX_VALID,
   output logic TX_READY,
   output logic [spc_pkg::WORD_W-1:0] RX_DATA,
   output logic RX_VALID,
   input wire logic MOSI_IN,
   output logic MOSI_OUT,
   output logic MOSI_OE,
   input wire logic MISO_IN,
   output logic MISO_OUT,
   output logic MISO_OE,
   input wire logic SCK_IN,
   output logic SCK_OUT,
   output logic SCK_OE,
   input wire logic SLAVE_SELECT_N_IN,
   output logic SLAVE_SELECT_N_OUT,
   output logic SLAVE_SELECT_N_OE
);

   typedef struct packed
   {
      spc_state_type st;
      logic [WORD_W-1:0] shreg;
      logic [2:0] bitcnt;
      logic [7:0] divcnt;
      logic [7:0] divisor;
      logic sck;
      logic sample;
      logic loaded;
      logic lost;
      logic [WORD_W-1:0] rx_data;
      logic rx_valid;
      logic [7:0] rdata;
      logic [1:0] sck_sync;
      logic [1:0] mosi_sync;
      logic [1:0] miso_sync;
      logic [1:0] sel_sync;
      logic sck_prev;
      logic sel_prev;
   } spc_unit_state_type;

   spc_unit_state_type s;
   spc_unit_state_type next_s;
   logic [WORD_W-1:0] fifo_data;
   logic fifo_valid;
   logic fifo_pop;
   logic master_on;
   logic slave_on;
   logic selected;
   logic sck_s;
   logic sel_s;
   logic mosi_s;
   logic miso_s;
   logic sel_fall;
   logic slave_rise;
   logic slave_fall;

   // ------------------------------------------------------------
   // Transmit buffer
   // ------------------------------------------------------------
   spc_fifo
   #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   )
   u_fifo
   (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .in_data(TX_DATA),
      .in_valid(TX_VALID),
      .in_ready(TX_READY),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop)
   );

   // ------------------------------------------------------------
   // Mode decode and pin directions
   // ------------------------------------------------------------
   assign sck_s = s.sck_sync[1];
   assign sel_s = s.sel_sync[1];
   assign mosi_s = s.mosi_sync[1];
   assign miso_s = s.miso_sync[1];
   assign master_on = ENABLE && MASTER && !s.lost;
   assign slave_on = ENABLE && !master_on;
   // Only mode 01 lets the select pin choose the slave
   assign selected = (SELECT_MODE != MODE_SELECT_IN) || !sel_s;
   assign sel_fall = s.sel_prev && !sel_s;
   // Clock edges are seen only while selected
   assign slave_rise = slave_on && selected && sck_s && !s.sck_prev;
   assign slave_fall = slave_on && selected && !sck_s && s.sck_prev;

   assign MOSI_OUT = s.shreg[WORD_W-1];
   assign MOSI_OE = master_on;
   assign MISO_OUT = s.shreg[WORD_W-1];
   assign MISO_OE = slave_on && selected;
   assign SCK_OUT = s.sck;
   assign SCK_OE = master_on;
   assign SLAVE_SELECT_N_OUT = SELECT_MODE[MODE_LEVEL_BIT];
   assign SLAVE_SELECT_N_OE = ENABLE && SELECT_MODE[MODE_OUT_BIT];
   assign SELECT_ROUTED = SELECT_MODE != MODE_THREE_WIRE;
   assign MASTER_LOST = s.lost;
   assign RX_DATA = s.rx_data;
   assign RX_VALID = s.rx_valid;
   assign SFR_RDATA = s.rdata;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      fifo_pop = 1'b0;
      next_s.sck_sync = {s.sck_sync[0], SCK_IN};
      next_s.mosi_sync = {s.mosi_sync[0], MOSI_IN};
      next_s.miso_sync = {s.miso_sync[0], MISO_IN};
      next_s.sel_sync = {s.sel_sync[0], SLAVE_SELECT_N_IN};
      next_s.sck_prev = sck_s;
      next_s.sel_prev = sel_s;
      next_s.rx_valid = 1'b0;
      if (SFR_WR && SFR_ADDR == DIVISOR_ADDR)
         next_s.divisor = SFR_WDATA;
      if (SFR_RD)
         next_s.rdata = (SFR_ADDR == DIVISOR_ADDR) ? s.divisor : 8'h00;
      if (CLEAR_LOST)
         next_s.lost = 1'b0;
      // Set wins over a clear in the same cycle
      if (ENABLE && MASTER && SELECT_MODE == MODE_SELECT_IN && sel_fall)
         next_s.lost = 1'b1;
      case (s.st)
         ST_IDLE:
         begin
            next_s.sck = 1'b0;
            next_s.divcnt = 8'h00;
            if (master_on)
            begin
               next_s.bitcnt = 3'h0;
               if (fifo_valid)
               begin
                  fifo_pop = 1'b1;
                  next_s.shreg = fifo_data;
                  next_s.st = ST_XFER;
               end
            end
            else if (!slave_on || !selected)
            begin
               next_s.bitcnt = 3'h0;
            end
            else
            begin
               if (!s.loaded && fifo_valid)
               begin
                  fifo_pop = 1'b1;
                  next_s.shreg = fifo_data;
                  next_s.loaded = 1'b1;
               end
               if (slave_rise)
                  next_s.sample = mosi_s;
               if (slave_fall)
               begin
                  next_s.shreg = {s.shreg[WORD_W-2:0], s.sample};
                  next_s.bitcnt = s.bitcnt + 3'h1;
                  if (s.bitcnt == LAST_BIT)
                  begin
                     next_s.rx_data = {s.shreg[WORD_W-2:0], s.sample};
                     next_s.rx_valid = 1'b1;
                     next_s.loaded = 1'b0;
                  end
               end
            end
         end
         ST_XFER:
         begin
            if (!master_on)
            begin
               next_s.st = ST_IDLE;
               next_s.bitcnt = 3'h0;
               next_s.sck = 1'b0;
            end
            else if (s.divcnt == s.divisor)
            begin
               // Half period is divisor+1 system clocks
               next_s.divcnt = 8'h00;
               next_s.sck = !s.sck;
               if (!s.sck)
               begin
                  next_s.sample = miso_s;
               end
               else
               begin
                  next_s.shreg = {s.shreg[WORD_W-2:0], s.sample};
                  next_s.bitcnt = s.bitcnt + 3'h1;
                  if (s.bitcnt == LAST_BIT)
                  begin
                     next_s.rx_data = {s.shreg[WORD_W-2:0], s.sample};
                     next_s.rx_valid = 1'b1;
                     next_s.st = ST_IDLE;
                  end
               end
            end
            else
            begin
               next_s.divcnt = s.divcnt + 8'h01;
            end
         end
         default:
         begin
            next_s.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         s <= '0;
         s.st <= ST_IDLE;
         s.divisor <= DIVISOR_RESET;
         s.sel_sync <= 2'h3;
         s.sel_prev <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (SYS_RST);

   chk_mosi_msb: assert property (
      (s.st == ST_XFER && master_on)
      |-> (MOSI_OE && MOSI_OUT == s.shreg[WORD_W-1]))
      else $error("data-out not driven from shift msb");
   chk_return_dir: assert property (
      master_on |-> !MISO_OE)
      else $error("return line driven while master");
   chk_return_float: assert property (
      (!ENABLE || (slave_on && SELECT_MODE == MODE_SELECT_IN && sel_s))
      |-> !MISO_OE)
      else $error("return line driven while off or unselected");
   chk_clock_dir: assert property (
      !master_on |-> !SCK_OE ##1 (s.st == ST_IDLE))
      else $error("clock driven while not master");
   chk_ignore_clock: assert property (
      (slave_on && SELECT_MODE == MODE_SELECT_IN && sel_s)
      |=> (s.bitcnt == 3'h0 && !RX_VALID))
      else $error("unselected slave counted clock edges");
   chk_select_out: assert property (
      (ENABLE && SELECT_MODE[1])
      |-> (SLAVE_SELECT_N_OE && SLAVE_SELECT_N_OUT == SELECT_MODE[0]))
      else $error("select output level wrong");
   chk_half_period: assert property (
      ($rose(s.sck) && s.st == ST_XFER && s.divisor == 8'h02 && master_on
      && $stable(s.divisor)) |=> s.sck [*2] ##1 !s.sck)
      else $error("clock half period wrong for divisor two");
   chk_master_lost: assert property (
      (ENABLE && MASTER && SELECT_MODE == MODE_SELECT_IN && sel_fall)
      |=> (MASTER_LOST && !SCK_OE && !MOSI_OE)
      ##1 (MASTER_LOST || $past(CLEAR_LOST)))
      else $error("select fall did not drop master function");
   chk_eight_bits: assert property (
      RX_VALID |-> (s.bitcnt == 3'h0 && s.st == ST_IDLE && !s.sck))
      else $error("word ended off an eight-bit boundary");

   cov_master_word: cover property (master_on && RX_VALID);
   cov_slave_word: cover property (slave_on && RX_VALID);
   cov_lost: cover property ($rose(MASTER_LOST));
   cov_fifo_full: cover property (!TX_READY);

endmodule : spc_unit

`default_nettype wire

// *** spc_far_slave.sv ***
// Far-end serial slave model facing the serial unit
// Assumes mode 0 timing: sample on rising clock, shift on falling
`default_nettype none

module spc_far_slave
(
   input wire logic sck,
   input wire logic mosi,
   input wire logic load,
   input wire logic [7:0] reply,
   output logic miso,
   output logic [7:0] got
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] sh = 8'h00;
   initial got = 8'h00;
   // Sole slave on the bus, always selected
   assign miso = sh[7];
   always @(posedge sck) got = {got[6:0], mosi};
   // Spent bits are replaced by inverted ones, never a held level
   always @(posedge load or negedge sck)
   begin
      if (load)
         sh = reply;
      else
         sh = {sh[6:0], ~sh[0]};
   end
endmodule : spc_far_slave

`default_nettype wire

// *** spi_pin_select_and_clock_rate_bench.sv ***
// Self-checking bench of the serial unit
// Assumes spc_pkg, spc_fifo and spc_unit are compiled first
`default_nettype none

module spi_pin_select_and_clock_rate_bench;
   import spc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DIV = 2;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata, rx_data, rx_last, got;
   logic [7:0] tx_data = 8'h00;
   logic [7:0] reply = 8'h00;
   logic [7:0] slave_out = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic enable = 1'b0;
   logic master = 1'b0;
   logic [1:0] mode = 2'h0;
   logic clear_lost = 1'b0;
   logic tx_valid = 1'b0;
   logic sck_drv = 1'b0;
   logic mosi_drv = 1'b0;
   logic sel_n = 1'b1;
   logic load = 1'b0;
   logic lost, routed, tx_ready, rx_valid, far_miso, sck_q;
   logic mosi_in, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
   logic sck_in, sck_out, sck_oe, ss_in, ss_out, ss_oe;
   int miscompares = 0;
   int num_checks = 0;
   int cyc = 0;
   int rises = 0;
   int last_rise = 0;
   int period = 0;
   int rx_cnt = 0;

   // ------------------------------------------------------------
   // Pin resolution, design and far end
   // ------------------------------------------------------------
   assign sck_in = sck_oe ? sck_out : sck_drv;
   assign mosi_in = mosi_oe ? mosi_out : mosi_drv;
   assign miso_in = miso_oe ? miso_out : far_miso;
   assign ss_in = ss_oe ? ss_out : sel_n;

   spc_unit spc_unit_i (.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
      .SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_WR(sfr_wr),
      .SFR_RD(sfr_rd), .SFR_RDATA(rdata), .ENABLE(enable),
      .MASTER(master), .SELECT_MODE(mode), .CLEAR_LOST(clear_lost),
      .MASTER_LOST(lost), .SELECT_ROUTED(routed), .TX_DATA(tx_data),
      .TX_VALID(tx_valid), .TX_READY(tx_ready), .RX_DATA(rx_data),
      .RX_VALID(rx_valid), .MOSI_IN(mosi_in), .MOSI_OUT(mosi_out),
      .MOSI_OE(mosi_oe), .MISO_IN(miso_in), .MISO_OUT(miso_out),
      .MISO_OE(miso_oe), .SCK_IN(sck_in), .SCK_OUT(sck_out),
      .SCK_OE(sck_oe), .SLAVE_SELECT_N_IN(ss_in),
      .SLAVE_SELECT_N_OUT(ss_out), .SLAVE_SELECT_N_OE(ss_oe));

   spc_far_slave spc_far_slave_i (.sck(sck_out), .mosi(mosi_out),
      .load(load), .reply(reply), .miso(far_miso), .got(got));

   // ------------------------------------------------------------
   // Clock, monitor and hang guard
   // ------------------------------------------------------------
   initial
   begin
      forever #10 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      sck_q <= sck_out;
      if (sck_out === 1'b1 && sck_q === 1'b0)
      begin
         rises <= rises + 1;
         period <= cyc - last_rise;
         last_rise <= cyc;
      end
      if (rx_valid === 1'b1)
      begin
         rx_cnt <= rx_cnt + 1;
         rx_last <= rx_data;
      end
      if (cyc == 10000)
      begin
         miscompares++;
         report_and_stop();
      end
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] exp,
      input logic [7:0] seen);
      num_checks++;
      if (seen !== exp)
      begin
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
         miscompares++;
      end
   endtask : check

   task automatic sfr(input logic wr, input logic [7:0] a,
      input logic [7:0] d);
      @(negedge sys_clk);
      addr = a;
      wdata = d;
      sfr_wr = wr;
      sfr_rd = !wr;
      @(negedge sys_clk);
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      @(negedge sys_clk);
   endtask : sfr

   task automatic cfg(input logic e, input logic m, input logic [1:0] md);
      @(negedge sys_clk);
      enable = e;
      master = m;
      mode = md;
      repeat (4) @(negedge sys_clk);
   endtask : cfg

   task automatic wait_rx(input int n);
      for (int i = 0; i < 3000 && rx_cnt < n; i++)
         @(negedge sys_clk);
   endtask : wait_rx

   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         @(negedge sys_clk);
         mosi_drv = b[i];
         repeat (4) @(negedge sys_clk);
         slave_out = {slave_out[6:0], miso_out};
         sck_drv = 1'b1;
         repeat (4) @(negedge sys_clk);
         sck_drv = 1'b0;
      end
      repeat (8) @(negedge sys_clk);
   endtask : send

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      sfr(1'b0, DIVISOR_ADDR, 8'h00);
      check("divisor reset", DIVISOR_RESET, rdata);
      sfr(1'b1, DIVISOR_ADDR, 8'(DIV));
      sfr(1'b1, 8'h33, 8'hFF);
      sfr(1'b0, DIVISOR_ADDR, 8'h00);
      check("divisor", 8'(DIV), rdata);
      sfr(1'b0, 8'h33, 8'h00);
      check("unmapped read", 8'h00, rdata);
   endtask : t_regs

   task automatic t_pins();
      logic [10:0] rows [7] = '{11'b00010_000011, 11'b11000_101000,
         11'b10000_010000, 11'b10011_000011, 11'b10010_010011,
         11'b11110_101111, 11'b11100_101101};
      foreach (rows[i])
      begin
         sel_n = rows[i][6];
         cfg(rows[i][10], rows[i][9], rows[i][8:7]);
         check("oe", {5'h00, rows[i][5:3]}, {5'h00, mosi_oe, miso_oe,
            sck_oe});
         check("select", {5'h00, rows[i][2:0]}, {5'h00, ss_oe, ss_out,
            routed});
      end
   endtask : t_pins

   task automatic t_master();
      int r0;
      int n0;
      cfg(1'b1, 1'b1, 2'h2);
      reply = 8'h96;
      load = 1'b1;
      r0 = rises;
      n0 = rx_cnt;
      @(negedge sys_clk);
      tx_data = 8'hA5;
      tx_valid = 1'b1;
      @(negedge sys_clk);
      tx_valid = 1'b0;
      load = 1'b0;
      wait_rx(n0 + 1);
      @(negedge sys_clk);
      check("far end got", 8'hA5, got);
      check("rx word", 8'h96, rx_last);
      check("sck rises", 8'h08, 8'(rises - r0));
      check("sck period", 8'(2 * (DIV + 1)), 8'(period));
      check("sck idle", 8'h00, {7'h00, sck_out});
   endtask : t_master

   task automatic t_fifo();
      int n = 0;
      int n0;
      cfg(1'b0, 1'b0, 2'h0);
      n0 = rx_cnt;
      tx_valid = 1'b1;
      while (tx_ready === 1'b1 && n < 40)
      begin
         tx_data = 8'(n);
         n++;
         @(negedge sys_clk);
      end
      tx_valid = 1'b0;
      check("fifo full", 8'h01, {7'h00, n == 32 || n == 33});
      cfg(1'b1, 1'b1, 2'h0);
      wait_rx(n0 + n);
      repeat (60) @(negedge sys_clk);
      check("drained words", 8'(n), 8'(rx_cnt - n0));
      check("fifo empty", 8'h01, {7'h00, tx_ready});
   endtask : t_fifo

   task automatic t_lost();
      sel_n = 1'b1;
      cfg(1'b1, 1'b1, 2'h1);
      sel_n = 1'b0;
      repeat (6) @(negedge sys_clk);
      check("lost", 8'h02, {6'h00, lost, sck_oe});
      sel_n = 1'b1;
      clear_lost = 1'b1;
      @(negedge sys_clk);
      clear_lost = 1'b0;
      repeat (2) @(negedge sys_clk);
      check("lost cleared", 8'h00, {7'h00, lost});
   endtask : t_lost

   task automatic t_slave();
      int n0;
      cfg(1'b1, 1'b0, 2'h1);
      n0 = rx_cnt;
      send(8'h5A);
      check("unselected rx", 8'(n0), 8'(rx_cnt));
      sel_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      send(8'hC3);
      check("selected rx", 8'hC3, rx_last);
      sel_n = 1'b1;
      cfg(1'b1, 1'b0, 2'h0);
      @(negedge sys_clk);
      tx_data = 8'h96;
      tx_valid = 1'b1;
      @(negedge sys_clk);
      tx_valid = 1'b0;
      repeat (4) @(negedge sys_clk);
      check("return msb", 8'h01, {7'h00, miso_out});
      send(8'h3C);
      check("three-wire rx", 8'h3C, rx_last);
      check("return word", 8'h96, slave_out);
   endtask : t_slave

   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   initial
   begin
      repeat (12) @(negedge sys_clk);
      sys_rst = 1'b0;
      t_regs();
      t_pins();
      t_master();
      t_fifo();
      t_lost();
      t_slave();
      report_and_stop();
   end
endmodule : spi_pin_select_and_clock_rate_bench

`default_nettype wire
